/* File: qss_pkg.sv */
package qss_pkg;
   localparam int NCH = 4;
   localparam int RES_W = 18;
   localparam int SPAN_W = 3;
   localparam int CFG_W = 12;
   localparam int CH_W = 2;
   localparam int BIT_W = 5;
   localparam logic [BIT_W-1:0] MSB_IDX = 5'h11;
   localparam logic [CH_W-1:0] LAST_CH = 2'h3;
   localparam logic [SPAN_W-1:0] SPAN_OFF = 3'h0;
   localparam logic [RES_W-1:0] RES_ZERO = 18'h00000;
   localparam logic [RES_W-1:0] SIGN_FLIP = 18'h20000;
   localparam logic [CFG_W-1:0] CFG_RST = 12'hFFF;
   // Lane count field: 0 means one lane, 3 means four
   localparam int LANE_W = 2;
   // APB offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_SPAN = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_RES0 = 8'h10;
   localparam int CTRL_LVDS = 0;
   localparam int CTRL_PD = 1;
   localparam int CTRL_LANE = 2;
   typedef enum logic [1:0] {
      QSS_ACQ = 2'b00,
      QSS_PICK = 2'b01,
      QSS_CONV = 2'b10,
      QSS_DONE = 2'b11
   } qss_state_e;
endpackage

/* File: qss_sequencer.sv */
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Operation
// - The block alternates between tracking inputs and converting them.
// - A rising conversion_start edge holds all four channels at once.
// - Held channels share one 18-bit dac, converted one after another.
// - Each channel runs a binary search from one half to 1/262144.
// - Results are published only after every channel has finished.
// - Each result is an 18-bit code covering 2^18 levels.
// - Each channel uses its own span code, latched at each conversion.
// - Span codes 7, 6, 3 and 2 are bipolar with two's complement output.
// - Unipolar spans give straight binary output.
// - Channels with span code zero are skipped and read as zero.
// - A pin picks CMOS or LVDS; CMOS allows one to four data lanes.
// - A power-down control stops conversions while idle.
// - Span codes 5, 4 and 1 are unipolar over non-negative inputs.
module qss_sequencer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic conversion_start_i,
   input wire logic lvds_sel_i,
   input wire logic comp_i,
   output logic [qss_pkg::NCH-1:0] hold_o,
   output logic [qss_pkg::CH_W-1:0] dac_ch_o,
   output logic [qss_pkg::RES_W-1:0] charge_redistribution_dac_o,
   output logic [qss_pkg::SPAN_W-1:0] dac_span_o,
   output logic lvds_mode_o,
   output logic [qss_pkg::LANE_W-1:0] lanes_o,
   output logic power_down_o,
   output logic results_valid_o
);
   import qss_pkg::*;

   qss_state_e state_r, state_nxt;
   logic cnv_d_r;
   logic [CFG_W-1:0] span_cfg_r;
   logic [CFG_W-1:0] span_lat_r;
   logic [LANE_W-1:0] lanes_r;
   logic pd_r;
   logic lvds_r;
   logic [CH_W-1:0] ch_r;
   logic [BIT_W-1:0] bit_r;
   logic [RES_W-1:0] sar_r;
   logic [RES_W-1:0] work_r [NCH];
   logic [RES_W-1:0] pub_r [NCH];
   logic valid_r;
   logic [31:0] rdata_r;
   logic ready_r;
   logic err_r;

   wire cnv_rise = conversion_start_i & ~cnv_d_r;
   wire acc = psel_i & penable_i & ~ready_r;
   // Write lands at the edge that completes the transfer
   wire wr = psel_i & penable_i & ready_r & pwrite_i;
   wire hit_ctrl = paddr_i == A_CTRL;
   wire hit_span = paddr_i == A_SPAN;
   wire hit_stat = paddr_i == A_STAT;
   wire [5:0] res_off = paddr_i[7:2] - A_RES0[7:2];
   wire hit_res = paddr_i >= A_RES0 && res_off < 6'(NCH)
      && paddr_i[1:0] == 2'h0;
   wire hit_any = hit_ctrl | hit_span | hit_stat | hit_res;
   wire [SPAN_W-1:0] cur_span = span_lat_r[ch_r*SPAN_W +: SPAN_W];
   wire ch_on = cur_span != SPAN_OFF;
   wire bipolar = cur_span[1];
   wire [RES_W-1:0] trial = sar_r | (RES_ZERO | (18'h1 << bit_r));
   wire [RES_W-1:0] kept = comp_i ? trial : sar_r;
   wire [RES_W-1:0] fmt = bipolar ? (kept ^ SIGN_FLIP) : kept;
   wire last_bit = bit_r == 5'h0;
   // Dac output is registered, so it is loaded with the next trial
   wire stepping = state_r == QSS_CONV && !last_bit;
   wire [RES_W-1:0] sar_nxt = stepping ? kept : RES_ZERO;
   wire [BIT_W-1:0] bit_nxt = stepping ? bit_r - 5'h1 : MSB_IDX;
   wire [RES_W-1:0] trial_nxt = sar_nxt | (RES_ZERO | (18'h1 << bit_nxt));

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         QSS_ACQ: begin
            if (cnv_rise && !pd_r) begin
               state_nxt = QSS_PICK;
            end
         end
         QSS_PICK: begin
            if (ch_on) begin
               state_nxt = QSS_CONV;
            end else if (ch_r == LAST_CH) begin
               state_nxt = QSS_DONE;
            end
         end
         QSS_CONV: begin
            if (last_bit) begin
               state_nxt = (ch_r == LAST_CH) ? QSS_DONE : QSS_PICK;
            end
         end
         QSS_DONE: begin
            state_nxt = QSS_ACQ;
         end
         default: begin
            state_nxt = QSS_ACQ;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= QSS_ACQ;
         cnv_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnv_d_r <= conversion_start_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         span_lat_r <= CFG_RST;
      end else if (state_r == QSS_ACQ && state_nxt == QSS_PICK) begin
         span_lat_r <= span_cfg_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch_r <= '0;
      end else if (state_r == QSS_ACQ || state_r == QSS_DONE) begin
         ch_r <= '0;
      end else if (state_r == QSS_PICK && !ch_on && ch_r != LAST_CH) begin
         ch_r <= ch_r + 2'h1;
      end else if (state_r == QSS_CONV && last_bit && ch_r != LAST_CH) begin
         ch_r <= ch_r + 2'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_r <= MSB_IDX;
         sar_r <= RES_ZERO;
      end else begin
         sar_r <= sar_nxt;
         bit_r <= bit_nxt;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               work_r[g] <= RES_ZERO;
               pub_r[g] <= RES_ZERO;
            end else begin
               if (state_r == QSS_PICK && ch_r == CH_W'(g) && !ch_on) begin
                  work_r[g] <= RES_ZERO;
               end else if (state_r == QSS_CONV && last_bit
                            && ch_r == CH_W'(g)) begin
                  work_r[g] <= fmt;
               end
               if (state_r == QSS_DONE) begin
                  pub_r[g] <= work_r[g];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         valid_r <= 1'b0;
      end else if (state_r == QSS_DONE) begin
         valid_r <= 1'b1;
      end else if (cnv_rise && state_r == QSS_ACQ && !pd_r) begin
         valid_r <= 1'b0;
      end
   end

   // span word and control over APB
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         span_cfg_r <= CFG_RST;
         pd_r <= 1'b0;
         lanes_r <= '0;
         lvds_r <= 1'b0;
      end else begin
         lvds_r <= lvds_sel_i;
         if (wr && hit_span) begin
            span_cfg_r <= pwdata_i[CFG_W-1:0];
         end
         if (wr && hit_ctrl) begin
            pd_r <= pwdata_i[CTRL_PD];
            lanes_r <= pwdata_i[CTRL_LANE +: LANE_W];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ready_r <= 1'b0;
         err_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ready_r <= psel_i & penable_i & ~ready_r;
         err_r <= acc & ~hit_any;
         if (acc && !pwrite_i) begin
            rdata_r <= hit_ctrl ? 32'({lanes_r, pd_r, lvds_r})
               : hit_span ? 32'(span_cfg_r)
               : hit_stat ? 32'({valid_r, state_r})
               : hit_res ? 32'(pub_r[res_off[CH_W-1:0]])
               : 32'h0;
         end
      end
   end

   always_comb begin
      prdata_o = rdata_r;
      pready_o = ready_r;
      pslverr_o = err_r;
      lvds_mode_o = lvds_r;
      lanes_o = lanes_r;
      power_down_o = pd_r;
      results_valid_o = valid_r;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_o <= '0;
      end else begin
         hold_o <= {NCH{state_nxt != QSS_ACQ}};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dac_ch_o <= '0;
         charge_redistribution_dac_o <= RES_ZERO;
         dac_span_o <= SPAN_OFF;
      end else begin
         dac_ch_o <= ch_r;
         charge_redistribution_dac_o <= trial_nxt;
         dac_span_o <= cur_span;
      end
   end

   sim_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_ACQ && cnv_rise && !pd_r |=> ##1 hold_o == 4'hF)
      else $error("hold not applied after start");
   pd_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_ACQ && pd_r |=> state_r == QSS_ACQ)
      else $error("conversion started in power-down");
   conv_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(state_r == QSS_CONV) |-> bit_r == MSB_IDX)
      else $error("search not started at msb");
   off_skip_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_PICK && !ch_on |=> state_r != QSS_CONV)
      else $error("disabled channel converted");
   order_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_CONV && last_bit && ch_r != LAST_CH
      |=> ch_r == $past(ch_r) + 2'h1)
      else $error("channel order broken");
   pub_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r != QSS_DONE |=> pub_r[0] == $past(pub_r[0]))
      else $error("result published early");
   valid_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_DONE |=> results_valid_o && state_r == QSS_ACQ)
      else $error("valid missing after pass");
   span_lat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_ACQ && state_nxt == QSS_PICK
      |=> span_lat_r == $past(span_cfg_r))
      else $error("span not latched");
   fmt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_CONV && last_bit && ch_r == 2'h0 && !bipolar
      |=> work_r[0] == $past(kept))
      else $error("unipolar result altered");

   // Steps of one pass, built from named sequences
   sequence s_start_taken;
      state_r == QSS_ACQ && cnv_rise && !pd_r;
   endsequence
   sequence s_pick_on;
      state_r == QSS_PICK && ch_on;
   endsequence
   sequence s_conv_first;
      state_r == QSS_CONV && bit_r == MSB_IDX;
   endsequence
   sequence s_conv_step;
      state_r == QSS_CONV && !last_bit;
   endsequence
   sequence s_conv_last;
      state_r == QSS_CONV && last_bit;
   endsequence
   start_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start_taken |=> state_r == QSS_PICK && ch_r == 2'h0)
      else $error("pass not started at channel zero");
   val_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_start_taken |=> !results_valid_o)
      else $error("stale results still flagged valid");
   pick_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pick_on |=> s_conv_first)
      else $error("enabled channel not converted");
   step_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_conv_step |=> state_r == QSS_CONV && bit_r == $past(bit_r) - 5'h1)
      else $error("search step skipped");
   exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_conv_last |=> state_r == QSS_PICK || state_r == QSS_DONE)
      else $error("channel search did not end");
   dac_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_CONV |-> charge_redistribution_dac_o == trial
      && dac_ch_o == ch_r && dac_span_o == cur_span)
      else $error("dac not driving current channel trial");
   bip_fmt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_conv_last ##0 (cur_span == 3'h7 || cur_span == 3'h6
      || cur_span == 3'h3 || cur_span == 3'h2)
      |-> fmt == (kept ^ SIGN_FLIP))
      else $error("bipolar result not in two's complement");
   uni_fmt_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_conv_last ##0 (cur_span == 3'h5 || cur_span == 3'h4
      || cur_span == 3'h1) |-> fmt == kept)
      else $error("unipolar result not straight binary");
   off_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      state_r == QSS_PICK && ch_r == 2'h0 && !ch_on
      |=> work_r[0] == RES_ZERO)
      else $error("disabled channel result not zero");
endmodule

/* File: qss_comp_model.sv */
`timescale 1ns/1ps
module qss_comp_model (
   input wire logic clk_i,
   input wire logic [3:0] hold_i,
   input wire logic [1:0] ch_i,
   input wire logic [17:0] dac_i,
   input wire logic [3:0][17:0] in_i,
   output logic comp_o
);
   logic [3:0][17:0] held_r;
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < 4; c++) begin
         if (!hold_i[c]) begin
            held_r[c] <= in_i[c];
         end
      end
   end
   assign comp_o = held_r[ch_i] >= dac_i;
endmodule

/* File: qss_sequencer_tb_top.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module qss_sequencer_tb_top;
   import qss_pkg::*;
   logic clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0;
   logic start = 0, lvds = 0, comp, pready, pslverr, err;
   logic lvds_mode, pd, valid;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [NCH-1:0] hold;
   logic [CH_W-1:0] dch;
   logic [RES_W-1:0] dac;
   logic [SPAN_W-1:0] dspan;
   logic [LANE_W-1:0] lanes;
   logic [3:0][17:0] smp = {18'h00001, 18'h3FFFF, 18'h15A3C, 18'h2A5C3};
   int n_fail = 0, n_compared = 0, cyc = 0;
   always #5 clk_i = ~clk_i;
   qss_sequencer u_qss_sequencer (.clk_i(clk_i), .rst_i(rst_i),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr),
      .conversion_start_i(start), .lvds_sel_i(lvds), .comp_i(comp),
      .hold_o(hold), .dac_ch_o(dch), .charge_redistribution_dac_o(dac),
      .dac_span_o(dspan), .lvds_mode_o(lvds_mode), .lanes_o(lanes),
      .power_down_o(pd), .results_valid_o(valid));
   qss_comp_model u_qss_comp_model (.clk_i(clk_i), .hold_i(hold),
      .ch_i(dch), .dac_i(dac), .in_i(smp), .comp_o(comp));
   task give_verdict;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict;
      end
   end
   // Waits on pready; only the cycle ceiling ends a hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1;
      @(posedge clk_i iff pready);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk_i);
   endtask
   task conv(input logic [11:0] w);
      logic [3:0][17:0] old;
      logic [2:0] s;
      logic [17:0] ex;
      logic bip;
      apb(1, A_SPAN, {20'h0, w});
      old = smp;
      start <= 1;
      @(posedge clk_i iff hold == 4'hF);
      start <= 0;
      `CHK(valid, 1'b0)
      // Inputs move while held; results must not follow
      smp <= ~smp;
      @(posedge clk_i iff valid);
      @(posedge clk_i);
      `CHK(hold, 4'h0)
      `CHK({dch, dspan, dac}, {2'h0, w[2:0], 18'h20000})
      for (int c = 0; c < 4; c++) begin
         apb(0, A_RES0 + 8'(4 * c), 32'h0);
         s = w[3 * c +: 3];
         bip = s == 3'h7 || s == 3'h6 || s == 3'h3 || s == 3'h2;
         ex = (s == 3'h0) ? RES_ZERO : bip ? old[c] ^ SIGN_FLIP : old[c];
         `CHK(rd[17:0], ex)
      end
      $display("test conversion %h done", w);
   endtask
   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 0;
      apb(0, A_SPAN, 32'h0);
      `CHK(rd[11:0], CFG_RST)
      apb(0, 8'h0C, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      $display("test reset and map done");
      lvds <= 1;
      apb(1, A_CTRL, 32'hE);
      apb(0, A_CTRL, 32'h0);
      `CHK(rd[3:0], 4'hF)
      `CHK({lvds_mode, pd, lanes}, 4'hF)
      start <= 1;
      repeat (6) @(posedge clk_i);
      `CHK({hold, valid}, 5'h0)
      start <= 0;
      lvds <= 0;
      apb(1, A_CTRL, 32'h0);
      `CHK({lvds_mode, pd, lanes}, 4'h0)
      $display("test power-down done");
      conv(12'h977);
      conv(12'h053);
      conv(12'h000);
      apb(0, A_STAT, 32'h0);
      `CHK(rd[2], 1'b1)
      give_verdict;
   end
endmodule
